// [ebp_regs.vh]
/*
 * register map, fields and timing counts of the external bus pins;
 * assumes a 32-bit AXI4-Lite slave
 */
`ifndef EBP_REGS_VH
`define EBP_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define EBP_OFS_CTRL 8'h00
`define EBP_OFS_PORTA 8'h04
`define EBP_OFS_DDRA 8'h08
`define EBP_OFS_PORTB 8'h0c
`define EBP_OFS_DDRB 8'h10
`define EBP_OFS_PORTE 8'h14
`define EBP_OFS_DDRE 8'h18
`define EBP_OFS_STAT 8'h1c
`define EBP_OFS_SLOWDIV 8'h20

// ----------------------------------------
// control register fields
// ----------------------------------------
`define EBP_CTRL_DIRECTION_PIN_ENABLE 0
`define EBP_CTRL_LSTRE 1
`define EBP_CTRL_BUS_ENABLE_DISABLE 2
`define EBP_CTRL_INVCLK 3
`define EBP_CTRL_CALE 4
`define EBP_CTRL_PIPOE 5
`define EBP_CTRL_RST 8'h00

// ----------------------------------------
// control port e bit positions
// ----------------------------------------
`define EBP_PE_SHARED 7
`define EBP_PE_QT1 6
`define EBP_PE_QT0 5
`define EBP_PE_LOW_BYTE_STROBE_N 3
`define EBP_PE_RW 2

// ----------------------------------------
// mode pins {special_n, b, a}; a high means expanded
// ----------------------------------------
`define EBP_MODE_NARROW 2'b01

// ----------------------------------------
// timing
// ----------------------------------------
`define EBP_QUARTER_CYCLES 4
`define EBP_SLOWDIV_RST 8'h00
`define EBP_RESP_OKAY 2'b00
`define EBP_RESP_SLVERR 2'b10

`endif

// [ebp_clk_div.v]
/*
 * e clock quarters and slow divider clock; assumes one core clock and a
 * divide value that changes only while the output idles
 */
`timescale 1ns/1ps
`include "ebp_regs.vh"

module ebp_clk_div #(
  parameter QUARTER_CYCLES = `EBP_QUARTER_CYCLES
) (
  input wire core_clk, // core clock
  input wire sys_rst, // async reset, high
  input wire [7:0] slow_div, // slow half period minus one, in quarters
  output reg [1:0] quarter, // e quarter, 2 and 3 are e high
  output wire quarter_end, // last cycle of a quarter
  output reg slow_clk // 50% duty slow clock
);
  reg [7:0] pre_cnt;
  reg [7:0] slow_cnt;

  assign quarter_end = (pre_cnt == QUARTER_CYCLES[7:0] - 8'h01);

  // ----------------------------------------
  // quarter counter
  // ----------------------------------------
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_cnt <= 8'h00;
      quarter <= 2'h0;
    end else if (quarter_end) begin
      pre_cnt <= 8'h00;
      quarter <= quarter + 2'h1;
    end else begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  // ----------------------------------------
  // slow clock: toggles on whole half periods, so duty stays exactly even
  // ----------------------------------------
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slow_cnt <= 8'h00;
      slow_clk <= 1'b0;
    end else if (quarter_end) begin
      if (slow_cnt >= slow_div) begin
        slow_cnt <= 8'h00;
        slow_clk <= ~slow_clk;
      end else begin
        slow_cnt <= slow_cnt + 8'h01;
      end
    end
  end
endmodule

// [ebp_pins.v]
/*
 * multiplexed expansion bus pins: ports a/b as address/data or gpio, control
 * port e; assumes a core access held until acc_done and an AXI4-Lite master
 */
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "ebp_regs.vh"

// Contract
// - single-chip modes give ports a and b to gpio, expanded modes to address/data.
// - in expanded mode the low-active data bus enable gates the drive during reads.
// - the shared pin can instead show the inverted e clock for address latching.
// - the shared pin can show the 50% slow divider clock, overridden by the bus enable.
// - mode pins are sampled at reset and then serve as queue tracking or gpio.
// - the e clock is driven out on its own pin as the bus timing reference.
// - the low byte strobe is address bit zero xnor byte-size, otherwise gpio.
// - in expanded modes the direction pin shows read or write, otherwise gpio.
// - the special mode pin picks special or normal mode at reset, then serves debug.
// - the bus enable is low only in e high, and only the last quarter when stretched.
// - narrow mode moves a 16-bit word as two cycles, high byte then low byte.
// - no external write happens until the direction function is enabled.
module ebp_pins #(
  parameter QUARTER_CYCLES = `EBP_QUARTER_CYCLES
) (
  input wire core_clk, // core clock
  input wire sys_rst, // async reset, high
  input wire [7:0] s_axi_awaddr, // aw addr
  input wire s_axi_awvalid, // aw valid
  output wire s_axi_awready, // aw ready
  input wire [31:0] s_axi_wdata, // w data
  input wire [3:0] s_axi_wstrb, // w strobes
  input wire s_axi_wvalid, // w valid
  output wire s_axi_wready, // w ready
  output reg [1:0] s_axi_bresp, // b resp
  output reg s_axi_bvalid, // b valid
  input wire s_axi_bready, // b ready
  input wire [7:0] s_axi_araddr, // ar addr
  input wire s_axi_arvalid, // ar valid
  output wire s_axi_arready, // ar ready
  output reg [31:0] s_axi_rdata, // r data
  output reg [1:0] s_axi_rresp, // r resp
  output reg s_axi_rvalid, // r valid
  input wire s_axi_rready, // r ready
  input wire acc_req, // access request, held to acc_done
  input wire acc_write, // 1 write
  input wire access_size_byte, // 1 byte access
  input wire [15:0] acc_addr, // access address
  input wire [15:0] acc_wdata, // big-endian write word
  input wire [1:0] acc_stretch, // extra e cycles
  output reg acc_done, // access end pulse
  output reg [15:0] acc_rdata, // read data
  input wire [1:0] queue_track_in, // core queue state
  input wire bdm_out, // debug drive level
  input wire bdm_oe, // debug drive enable
  output wire bdm_in, // debug level seen
  input wire [7:0] port_a_in, // pin levels
  output reg [7:0] port_a_out, // drive levels
  output reg [7:0] port_a_oe, // drive enables
  input wire [7:0] port_b_in, // pin levels
  output reg [7:0] port_b_out, // drive levels
  output reg [7:0] port_b_oe, // drive enables
  input wire [7:0] port_e_in, // pin levels
  output reg [7:0] port_e_out, // drive levels
  output reg [7:0] port_e_oe, // drive enables
  output reg bus_clock_out, // e clock pin
  input wire special_mode_select_n, // special mode pin
  output wire background_debug_pin_out, // debug pin level
  output wire background_debug_pin_oe // debug pin enable
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_CYC = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg [7:0] ctrl, dat_a, ddr_a, dat_b, ddr_b, dat_e, ddr_e, slow_div;
  reg [2:0] mode;
  reg mode_cap;
  reg [2:0] state;
  reg [1:0] stretch_left;
  reg second;
  reg aw_hold, w_hold;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire [1:0] quarter;
  wire quarter_end;
  wire slow_clk;

  // pin read-back: driven bits show the latch, the rest the pin
  function [7:0] port_view;
    input [7:0] d;
    input [7:0] ddr;
    input [7:0] pin;
    begin
      port_view = (d & ddr) | (pin & ~ddr);
    end
  endfunction

  ebp_clk_div #(.QUARTER_CYCLES(QUARTER_CYCLES)) u_div (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .slow_div(slow_div),
    .quarter(quarter),
    .quarter_end(quarter_end),
    .slow_clk(slow_clk)
  );

  // ----------------------------------------
  // mode capture at reset release
  // ----------------------------------------
  wire expanded = mode_cap & mode[0];
  wire narrow = mode[1:0] == `EBP_MODE_NARROW;
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= 3'h0;
      mode_cap <= 1'b0;
    end else if (!mode_cap) begin
      // port e pins are undriven until now, so these show the straps
      mode <= {special_mode_select_n, port_e_in[`EBP_PE_QT1],
               port_e_in[`EBP_PE_QT0]};
      mode_cap <= 1'b1;
    end
  end
  // debug pin belongs to the debug logic only once the mode is fixed
  assign background_debug_pin_out = bdm_out;
  assign background_debug_pin_oe = mode_cap & bdm_oe;
  assign bdm_in = special_mode_select_n;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_got = aw_hold | aw_take;
  wire w_got = w_hold | w_take;
  wire do_wr = aw_got & w_got & ~s_axi_bvalid;
  wire [7:0] wa = aw_hold ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_hold ? w_data : s_axi_wdata;
  wire [3:0] ws = w_hold ? w_strb : s_axi_wstrb;
  wire wr_ok = (wa <= `EBP_OFS_SLOWDIV) && (wa[1:0] == 2'b00) && (wa != `EBP_OFS_STAT);
  assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EBP_RESP_OKAY;
      ctrl <= `EBP_CTRL_RST;
      dat_a <= 8'h00;
      ddr_a <= 8'h00;
      dat_b <= 8'h00;
      ddr_b <= 8'h00;
      dat_e <= 8'h00;
      ddr_e <= 8'h00;
      slow_div <= `EBP_SLOWDIV_RST;
    end else begin
      if (aw_take && !do_wr) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take && !do_wr) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `EBP_RESP_OKAY : `EBP_RESP_SLVERR;
        if (ws[0]) begin
          case (wa)
            `EBP_OFS_CTRL: ctrl <= wd[7:0];
            `EBP_OFS_PORTA: dat_a <= wd[7:0];
            `EBP_OFS_DDRA: ddr_a <= wd[7:0];
            `EBP_OFS_PORTB: dat_b <= wd[7:0];
            `EBP_OFS_DDRB: ddr_b <= wd[7:0];
            `EBP_OFS_PORTE: dat_e <= wd[7:0];
            `EBP_OFS_DDRE: ddr_e <= wd[7:0];
            `EBP_OFS_SLOWDIV: slow_div <= wd[7:0];
            default: ;
          endcase
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `EBP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `EBP_RESP_OKAY;
      case (s_axi_araddr)
        `EBP_OFS_CTRL: s_axi_rdata <= {24'h0, ctrl};
        `EBP_OFS_PORTA: s_axi_rdata <= {24'h0, port_view(dat_a, ddr_a, port_a_in)};
        `EBP_OFS_DDRA: s_axi_rdata <= {24'h0, ddr_a};
        `EBP_OFS_PORTB: s_axi_rdata <= {24'h0, port_view(dat_b, ddr_b, port_b_in)};
        `EBP_OFS_DDRB: s_axi_rdata <= {24'h0, ddr_b};
        `EBP_OFS_PORTE: s_axi_rdata <= {24'h0, port_view(dat_e, ddr_e, port_e_in)};
        `EBP_OFS_DDRE: s_axi_rdata <= {24'h0, ddr_e};
        `EBP_OFS_STAT: s_axi_rdata <= {27'h0, state == ST_CYC, mode_cap, mode};
        `EBP_OFS_SLOWDIV: s_axi_rdata <= {24'h0, slow_div};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `EBP_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // bus cycle sequencer: cycles start at e quarter 0
  // ----------------------------------------
  wire wr_allowed = ctrl[`EBP_CTRL_DIRECTION_PIN_ENABLE];
  wire wide16 = narrow & ~access_size_byte;
  wire cyc_end = quarter_end & (quarter == 2'h3);
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      stretch_left <= 2'h0;
      second <= 1'b0;
      acc_done <= 1'b0;
      acc_rdata <= 16'h0;
    end else begin
      acc_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (acc_req && mode_cap && !expanded) begin
            state <= ST_DONE; // no external bus in single-chip modes
            acc_done <= 1'b1;
            acc_rdata <= 16'h0;
          end else if (acc_req && expanded && quarter_end && quarter == 2'h3) begin
            state <= ST_CYC;
            stretch_left <= acc_stretch;
            second <= 1'b0;
          end
        end
        ST_CYC: begin
          if (cyc_end) begin
            if (stretch_left != 2'h0) begin
              stretch_left <= stretch_left - 2'h1;
            end else begin
              if (!acc_write) begin
                if (!narrow) begin
                  acc_rdata <= {port_a_in, port_b_in};
                end else if (wide16 && !second) begin
                  acc_rdata[15:8] <= port_a_in;
                end else if (wide16 || acc_addr[0]) begin
                  acc_rdata[7:0] <= port_a_in;
                end else begin
                  acc_rdata[15:8] <= port_a_in;
                end
              end
              if (wide16 && !second) begin
                second <= 1'b1;
                stretch_left <= acc_stretch;
              end else begin
                state <= ST_DONE;
                acc_done <= 1'b1;
              end
            end
          end
        end
        ST_DONE: begin
          if (!acc_req)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  wire e_high = quarter[1];
  wire busy = state == ST_CYC;
  wire [15:0] cur_addr = acc_addr | {15'h0, second};
  wire drive_data = busy & acc_write & wr_allowed & e_high;
  wire last_cyc = busy & (stretch_left == 2'h0);
  // bus enable only in e high; when stretched only the final quarter
  wire dbe_act = last_cyc & ~acc_write & e_high &
                 ((acc_stretch == 2'h0) | (quarter == 2'h3));

  reg [7:0] next_a_out, next_a_oe, next_b_out, next_b_oe, next_e_out, next_e_oe;
  always @* begin
    next_a_out = dat_a;
    next_a_oe = ddr_a;
    next_b_out = dat_b;
    next_b_oe = ddr_b;
    next_e_out = dat_e;
    next_e_oe = mode_cap ? ddr_e : 8'h00;
    if (expanded) begin
      next_a_oe = 8'hff;
      next_b_oe = 8'hff;
      next_a_out = cur_addr[15:8];
      next_b_out = cur_addr[7:0];
      if (e_high) begin
        if (!narrow) begin
          next_a_out = acc_wdata[15:8];
          next_b_out = acc_wdata[7:0];
          next_a_oe = {8{drive_data}};
          next_b_oe = {8{drive_data}};
        end else begin
          next_a_out = cur_addr[0] ? acc_wdata[7:0] : acc_wdata[15:8];
          next_a_oe = {8{drive_data}};
        end
      end
      if (ctrl[`EBP_CTRL_DIRECTION_PIN_ENABLE]) begin
        next_e_out[`EBP_PE_RW] = ~(busy & acc_write);
        next_e_oe[`EBP_PE_RW] = 1'b1;
      end
      if (ctrl[`EBP_CTRL_PIPOE]) begin
        next_e_out[`EBP_PE_QT1] = queue_track_in[1];
        next_e_out[`EBP_PE_QT0] = queue_track_in[0];
        next_e_oe[`EBP_PE_QT1] = 1'b1;
        next_e_oe[`EBP_PE_QT0] = 1'b1;
      end
    end
    if (mode_cap && ctrl[`EBP_CTRL_LSTRE]) begin
      next_e_out[`EBP_PE_LOW_BYTE_STROBE_N] = ~(cur_addr[0] ^ access_size_byte);
      next_e_oe[`EBP_PE_LOW_BYTE_STROBE_N] = 1'b1;
    end
    // shared pin: inverted clock beats bus enable beats calibration clock
    if (expanded && !ctrl[`EBP_CTRL_BUS_ENABLE_DISABLE]) begin
      next_e_oe[`EBP_PE_SHARED] = 1'b1;
      if (ctrl[`EBP_CTRL_INVCLK])
        next_e_out[`EBP_PE_SHARED] = ~e_high;
      else
        next_e_out[`EBP_PE_SHARED] = ~dbe_act;
    end else if (mode_cap && ctrl[`EBP_CTRL_CALE]) begin
      next_e_oe[`EBP_PE_SHARED] = 1'b1;
      next_e_out[`EBP_PE_SHARED] = slow_clk;
    end
    next_e_oe[4] = 1'b0;
    next_e_out[4] = 1'b0;
  end

  // e clock and pins share one register stage so their phases stay aligned
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_a_out <= 8'h00;
      port_a_oe <= 8'h00;
      port_b_out <= 8'h00;
      port_b_oe <= 8'h00;
      port_e_out <= 8'h00;
      port_e_oe <= 8'h00;
      bus_clock_out <= 1'b0;
    end else begin
      port_a_out <= next_a_out;
      port_a_oe <= next_a_oe;
      port_b_out <= next_b_out;
      port_b_oe <= next_b_oe;
      port_e_out <= next_e_out;
      port_e_oe <= next_e_oe;
      bus_clock_out <= e_high;
    end
  end
endmodule

// [ebp_pins_sva.sv]
/*
 * checker bound to ebp_pins; assumes QUARTER_CYCLES of the bound instance
 */
`timescale 1ns/1ps

module ebp_pins_chk #(
  parameter QUARTER_CYCLES = 4
) (
  input wire core_clk, // core clock
  input wire sys_rst, // async reset
  input wire [1:0] s_axi_bresp, // write response
  input wire s_axi_bvalid, // response valid
  input wire s_axi_bready, // response ready
  input wire acc_req, // access request
  input wire access_size_byte, // byte access
  input wire [15:0] acc_addr, // access address
  input wire [1:0] acc_stretch, // stretch count
  input wire acc_done, // access end
  input wire [7:0] port_a_oe, // port a enables
  input wire [7:0] port_e_out, // port e levels
  input wire [7:0] port_e_oe, // port e enables
  input wire bus_clock_out, // e clock
  input wire special_mode_select_n, // mode pin
  input wire bdm_in // debug receive
);
  reg [7:0] hi_cnt;
  reg [7:0] lo_cnt;
  wire rd_dir = port_e_oe[2] && port_e_out[2];
  wire wr_dir = port_e_oe[2] && !port_e_out[2];
  wire bus_en_low = port_e_oe[7] && !port_e_out[7];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------
  // run counters
  // ----------------------------------------
  // phase lengths exceed what a repetition may unroll, so they are counted
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_cnt <= 8'h00;
      lo_cnt <= 8'h00;
    end else begin
      hi_cnt <= bus_clock_out ? hi_cnt + 8'h01 : 8'h00;
      lo_cnt <= bus_en_low ? lo_cnt + 8'h01 : 8'h00;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_dbe_e_high: assert property (acc_req && rd_dir && bus_en_low |-> bus_clock_out)
    else $error("bus enable low outside e high");
  a_dbe_stretch: assert property (
    acc_req && acc_stretch != 2'h0 && bus_en_low |-> lo_cnt < QUARTER_CYCLES)
    else $error("bus enable low beyond last quarter");
  a_read_release: assert property (
    acc_done && rd_dir |-> bus_en_low && bus_clock_out && port_a_oe == 8'h00)
    else $error("read end without released lane");
  a_write_drive: assert property (acc_done && wr_dir |-> bus_clock_out && port_a_oe == 8'hff)
    else $error("write data not driven in e high");
  a_strobe_xnor: assert property (
    acc_done && port_e_oe[3] |-> port_e_out[3] == ~(acc_addr[0] ^ access_size_byte))
    else $error("low byte strobe wrong");
  a_done_pulse: assert property (acc_done |=> !acc_done)
    else $error("done longer than one cycle");
  a_done_bound: assert property ($rose(acc_req) |-> ##[1:200] acc_done)
    else $error("access never ended");
  a_bus_clock_out_high: assert property ($fell(bus_clock_out) |-> hi_cnt == 2 * QUARTER_CYCLES)
    else $error("e high phase length wrong");
  a_bdm_follow: assert property (bdm_in == special_mode_select_n)
    else $error("debug pin level not passed on");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  c_read: cover property (acc_done && rd_dir);
  c_write: cover property (acc_done && wr_dir);
  c_stretch: cover property (acc_req && acc_stretch != 2'h0 && bus_en_low);
endmodule

bind ebp_pins ebp_pins_chk #(.QUARTER_CYCLES(QUARTER_CYCLES)) i_ebp_pins_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .acc_req(acc_req),
  .access_size_byte(access_size_byte), .acc_addr(acc_addr), .acc_stretch(acc_stretch),
  .acc_done(acc_done), .port_a_oe(port_a_oe), .port_e_out(port_e_out),
  .port_e_oe(port_e_oe), .bus_clock_out(bus_clock_out),
  .special_mode_select_n(special_mode_select_n), .bdm_in(bdm_in)
);

// [ebp_ext_mem.sv]
/*
 * external word memory on the bus; assumes the bench resolves the pins
 */
`timescale 1ns/1ps

module ebp_ext_mem (
  input wire core_clk, // core clock
  input wire narrow, // data on port a only
  input wire bus_clock_out, // e clock
  input wire [7:0] pa, // port a level
  input wire [7:0] pb, // port b level
  input wire [7:0] pe_out, // port e levels
  input wire [7:0] pe_oe, // port e enables
  output wire drv, // memory drives the lanes
  output wire [7:0] drv_a, // port a data
  output wire [7:0] drv_b // port b data
);
  reg [15:0] mem [0:15];
  reg [15:0] adr;
  reg [15:0] wbuf;
  reg wr_seen = 1'h0;
  integer i;
  wire [15:0] word = mem[adr[4:1]];
  wire wr_dir = pe_oe[2] && !pe_out[2];

  initial begin
    for (i = 0; i < 16; i = i + 1) begin
      mem[i] = {4'h3 ^ i[3:0], i[3:0], 4'hc, i[3:0]};
    end
  end

  // ----------------------------------------
  // address latch and write capture
  // ----------------------------------------
  // a register loaded on every core clock of e low keeps the last address seen before e rises
  always @(posedge core_clk) begin
    if (!bus_clock_out) begin
      adr <= {pa, pb};
      wr_seen <= 1'h0;
    end else if (wr_dir) begin
      wbuf <= {pa, pb};
      wr_seen <= 1'h1;
    end
  end

  always @(negedge bus_clock_out) begin
    if (wr_seen && !narrow) begin
      mem[adr[4:1]] <= wbuf;
    end
  end

  // answers only while the bus enable marks a read in e high
  assign drv = bus_clock_out && pe_oe[7] && !pe_out[7] && !wr_dir;
  assign drv_a = (narrow && adr[0]) ? word[7:0] : word[15:8];
  assign drv_b = word[7:0];
endmodule

// [ebp_pins_tb.sv]
/*
 * self-checking bench of the bus pins with a memory; assumes a 250 MHz clock
 */
`timescale 1ns/1ps
`include "ebp_regs.vh"

module ebp_pins_tb;
  localparam int QC = 2;
  reg core_clk = 1'h0;
  reg sys_rst = 1'h1;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pa_prev = 8'h00, pb_prev = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
  reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  reg acc_req = 1'h0, acc_write = 1'h0, access_size_byte = 1'h0;
  reg [15:0] acc_addr = 16'h0, acc_wdata = 16'h0;
  reg [1:0] acc_stretch = 2'h0, queue_track_in = 2'h0, strap = 2'h3;
  reg bdm_out = 1'h0, bdm_oe = 1'h0, special_mode_select_n = 1'h1;
  wire acc_done, bdm_in, bus_clock_out, background_debug_pin_out, background_debug_pin_oe;
  wire drv;
  wire [15:0] acc_rdata;
  wire [7:0] port_a_out, port_a_oe, port_b_out, port_b_oe, port_e_out, port_e_oe, drv_a, drv_b;
  int mismatches = 0, cmp_count = 0;
  // released lanes flip every cycle so a stale level never passes for data
  wire [7:0] port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & (drv ? drv_a : ~pa_prev));
  wire [7:0] port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & (drv ? drv_b : ~pb_prev));
  wire [7:0] port_e_in = (port_e_oe & port_e_out) | (~port_e_oe & {1'h1, strap, 5'h1f});

  ebp_pins #(.QUARTER_CYCLES(QC)) i_ebp_pins (.*);
  ebp_ext_mem i_ebp_ext_mem (.core_clk(core_clk), .narrow(strap == 2'h1),
    .bus_clock_out(bus_clock_out), .pa(port_a_in), .pb(port_b_in), .pe_out(port_e_out),
    .pe_oe(port_e_oe), .drv(drv), .drv_a(drv_a), .drv_b(drv_b));

  initial begin
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    pa_prev <= port_a_in;
    pb_prev <= port_b_in;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] s);
    sys_rst <= 1'h1;
    strap <= s;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'h0;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic core(input logic w, input logic b, input logic [15:0] a, input logic [15:0] wd,
                      input logic [1:0] st, output logic [15:0] rd);
    acc_write <= w;
    access_size_byte <= b;
    acc_addr <= a;
    acc_wdata <= wd;
    acc_stretch <= st;
    acc_req <= 1'h1;
    do @(posedge core_clk); while (acc_done !== 1'h1);
    rd = acc_rdata;
    acc_req <= 1'h0;
    @(posedge core_clk);
  endtask

  task automatic run_len(input logic lvl, output int n);
    n = 0;
    while (port_e_out[7] !== lvl) @(posedge core_clk);
    while (port_e_out[7] === lvl) begin
      n++;
      @(posedge core_clk);
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(`EBP_OFS_CTRL, d, r);
    check(d, 32'h0);
    axi_rd(`EBP_OFS_STAT, d, r);
    check(d[3:0], 4'hf);
    axi_rd(8'h40, d, r);
    check({r, d[29:0]}, {`EBP_RESP_SLVERR, 30'h0});
    axi_wr(`EBP_OFS_STAT, 32'h0, r);
    check(r, `EBP_RESP_SLVERR);
    $display("t_regs finished");
  endtask

  task automatic t_no_write;
    logic [15:0] old, rd;
    old = i_ebp_ext_mem.mem[2];
    core(1'h1, 1'h0, 16'h0004, 16'h1234, 2'h0, rd);
    check(i_ebp_ext_mem.mem[2], old);
    check(port_e_oe[2], 1'h0);
    $display("t_no_write finished");
  endtask

  task automatic t_wide;
    logic [15:0] rd;
    logic [1:0] r;
    axi_wr(`EBP_OFS_CTRL, 32'h3, r);
    core(1'h1, 1'h0, 16'h0006, 16'ha55a, 2'h0, rd);
    check(i_ebp_ext_mem.mem[3], 16'ha55a);
    core(1'h0, 1'h0, 16'h0006, 16'h0, 2'h0, rd);
    check(rd, 16'ha55a);
    core(1'h0, 1'h0, 16'h000a, 16'h0, 2'h2, rd);
    check(rd, i_ebp_ext_mem.mem[5]);
    core(1'h0, 1'h1, 16'h000b, 16'h0, 2'h0, rd);
    check(rd[7:0], i_ebp_ext_mem.mem[5][7:0]);
    $display("t_wide finished");
  endtask

  task automatic t_shared;
    int n, hi, lo;
    logic [1:0] r;
    axi_wr(`EBP_OFS_CTRL, 32'h08, r);
    repeat (3) @(posedge core_clk);
    n = 0;
    repeat (16) begin
      @(posedge core_clk);
      if (port_e_out[7] !== ~bus_clock_out || port_e_oe[7] !== 1'h1) n++;
    end
    check(n, 0);
    axi_wr(`EBP_OFS_SLOWDIV, 32'h1, r);
    axi_wr(`EBP_OFS_CTRL, 32'h14, r);
    run_len(1'h0, lo);
    run_len(1'h1, hi);
    run_len(1'h0, lo);
    check(hi, 2 * QC);
    check(lo, 2 * QC);
    axi_wr(`EBP_OFS_CTRL, 32'h10, r);
    n = 0;
    repeat (32) begin
      @(posedge core_clk);
      if (port_e_out[7] !== 1'h1) n++;
    end
    check(n, 0);
    $display("t_shared finished");
  endtask

  task automatic t_narrow;
    logic [31:0] d;
    logic [15:0] rd;
    logic [1:0] r;
    do_reset(2'h1);
    axi_rd(`EBP_OFS_STAT, d, r);
    check(d[3:0], 4'hd);
    core(1'h0, 1'h0, 16'h0008, 16'h0, 2'h0, rd);
    check(rd, i_ebp_ext_mem.mem[4]);
    core(1'h0, 1'h1, 16'h0009, 16'h0, 2'h0, rd);
    check(rd[7:0], i_ebp_ext_mem.mem[4][7:0]);
    $display("t_narrow finished");
  endtask

  task automatic t_single;
    logic [15:0] rd;
    logic [1:0] r;
    do_reset(2'h0);
    axi_wr(`EBP_OFS_DDRA, 32'hff, r);
    axi_wr(`EBP_OFS_PORTA, 32'h5a, r);
    @(posedge core_clk);
    check({port_a_oe, port_a_out}, 16'hff5a);
    core(1'h0, 1'h0, 16'h0002, 16'h0, 2'h0, rd);
    check(rd, 16'h0);
    $display("t_single finished");
  endtask

  initial begin
    #200000;
    mismatches++;
    summarize();
  end

  initial begin
    do_reset(2'h3);
    t_regs();
    t_no_write();
    t_wide();
    t_shared();
    t_narrow();
    t_single();
    summarize();
  end
endmodule
